// ==== shared/cpu_bus_pkg.sv ====
package cpu_bus_pkg;
   // Bus widths
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   // Directly addressed I/O ports: 512 needs 9 bits
   localparam int IO_W = 9;
   // General registers held as three pairs
   localparam int NUM_GP = 6;
   // Register select codes beyond the six general registers
   localparam logic [2:0] SEL_ACC = 3'h6;
   localparam logic [2:0] SEL_FLG = 3'h7;
   // Pair select code that reaches the stack pointer
   localparam logic [2:0] SEL_SP = 3'h3;
   // Flag bit positions
   localparam int FLAG_W = 5;
   localparam int FLG_CY = 0;
   localparam int FLG_P = 1;
   localparam int FLG_AC = 2;
   localparam int FLG_Z = 3;
   localparam int FLG_S = 4;
   // Reset values
   localparam logic [15:0] PC_RST = 16'h0000;
   localparam logic [15:0] SP_RST = 16'h0000;
   localparam logic [7:0] REG_RST = 8'h00;
   localparam logic [4:0] FLG_RST = 5'h00;

   // Micro-operations issued by the instruction engine
   // Bus writes sit on odd codes, so bit zero alone tells write from read
   typedef enum logic [3:0] {
      OP_NOP, OP_MWR, OP_FETCH, OP_IWR, OP_MRD, OP_PUSH,
      OP_IRD, OP_LDR, OP_POP, OP_LDP, OP_ADD, OP_HALT
   } op_t;

   // One command: operation, register select, immediate, last flag
   typedef struct packed {
      op_t op;
      logic [2:0] sel;
      logic [15:0] imm;
      logic last;
   } cmd_t;

   // Machine-cycle states, Gray along T1-T2-T3-T4
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_T1 = 3'b001,
      ST_T2 = 3'b011,
      ST_T3 = 3'b010,
      ST_T4 = 3'b110,
      ST_TW = 3'b111,
      ST_HOLD_WAIT = 3'b100,
      ST_HALT = 3'b101
   } state_t;

   // Address and data pins with their enables
   typedef struct packed {
      logic [15:0] addr;
      logic addrOe;
      logic [7:0] data;
      logic dataOe;
   } bus_out_t;
endpackage

// ==== core/cpu_bus_control_core.sv ====
`timescale 1ns/10ps
module cpu_bus_control_core (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Instruction engine side
   input wire logic cmdValid,
   input wire cpu_bus_pkg::cmd_t cmd,
   output logic cmdReady,
   output logic [7:0] rdData,
   output logic rdValid,
   input wire logic irqEnSet,
   input wire logic irqEnClr,
   output logic irqTake,
   // Pins
   output cpu_bus_pkg::bus_out_t busOut,
   input wire logic [7:0] dataIn,
   input wire logic readyIn,
   input wire logic holdReq,
   input wire logic irqReq,
   output logic syncOut,
   output logic ioSelect,
   output logic data_in_strobe,
   output logic writeStrobe_n,
   output logic waitOut,
   output logic bus_hold_ack,
   output logic irq_enabled_out
);
   import cpu_bus_pkg::*;

   state_t stateFf, nxtState; // Machine-cycle state
   logic phaseFf; // 0: first phase, 1: second phase
   logic [1:0] holdSyncFf, irqSyncFf; // Pin synchronisers
   logic holdS, irqS; // Synchronised requests
   logic holdPendFf; // Hold seen in T2 or wait
   logic [7:0] gpFf [NUM_GP]; // General registers
   logic [7:0] accFf; // Accumulator
   logic [FLAG_W-1:0] flgFf; // Condition flags
   logic [15:0] pcFf, spFf; // Program counter, stack pointer
   cmd_t curFf; // Command owning the bus cycle
   logic [15:0] addrFf; // Latched cycle address
   logic [7:0] wdataFf; // Latched write data
   logic accept, busOp, haltSt, sampleNow, takeNow;
   logic [8:0] sum; // Adder with carry out
   logic [7:0] opnd; // Second operand of the adder

   // Byte read from any register select
   function automatic logic [7:0] rdReg(input logic [2:0] s);
      if (s == SEL_ACC)
         rdReg = accFf;
      else if (s == SEL_FLG)
         rdReg = {3'h0, flgFf};
      else
         rdReg = gpFf[s];
   endfunction

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   // Hold and interrupt pins are asynchronous: two flops each
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         holdSyncFf <= 2'h0;
         irqSyncFf <= 2'h0;
      end else begin
         holdSyncFf <= {holdSyncFf[0], holdReq};
         irqSyncFf <= {irqSyncFf[0], irqReq};
      end
   end
   assign holdS = holdSyncFf[1];
   assign irqS = irqSyncFf[1];

   // Two-phase divider: each T state spans two clocks
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst)
         phaseFf <= 1'b0;
      else
         phaseFf <= ~phaseFf;
   end

   assign accept = cmdValid && cmdReady;
   assign busOp = cmd.op inside {OP_FETCH, OP_MRD, OP_MWR, OP_IRD,
                                 OP_IWR, OP_PUSH, OP_POP};
   assign haltSt = (stateFf == ST_HALT);
   // Operand in a process, so a register write re-evaluates the adder
   always_comb begin
      opnd = rdReg(cmd.sel);
      sum = {1'b0, accFf} + {1'b0, opnd};
   end

   // Next machine-cycle state, moved only at the end of phase two
   always_comb begin
      nxtState = stateFf;
      if (phaseFf) begin
         case (stateFf)
            ST_IDLE: begin
               if (accept && busOp)
                  nxtState = ST_T1;
               else if (accept && cmd.op == OP_HALT)
                  nxtState = ST_HALT;
               else if (holdS && !accept)
                  nxtState = ST_HOLD_WAIT;
            end
            ST_T1: nxtState = ST_T2;
            ST_T2, ST_TW: nxtState = readyIn ? ST_T3 : ST_TW;
            ST_T3: nxtState = ST_T4;
            ST_T4: nxtState = holdPendFf ? ST_HOLD_WAIT : ST_IDLE;
            ST_HOLD_WAIT: nxtState = holdS ? ST_HOLD_WAIT : ST_IDLE;
            // Interrupt found in phase one is registered for phase two
            ST_HALT: nxtState = irqTake ? ST_IDLE : ST_HALT;
            default: nxtState = ST_IDLE;
         endcase
      end
   end

   // State register
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst)
         stateFf <= ST_IDLE;
      else
         stateFf <= nxtState;
   end

   // hold sampled in T2 and wait states
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst)
         holdPendFf <= 1'b0;
      else if (phaseFf && (stateFf == ST_T2 || stateFf == ST_TW))
         holdPendFf <= holdS;
      else if (stateFf == ST_IDLE)
         holdPendFf <= 1'b0;
   end

   // Ready for a command only in phase two of an idle T state
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst)
         cmdReady <= 1'b0;
      else
         cmdReady <= (nxtState == ST_IDLE) && !phaseFf && !holdS;
   end

   // Latch what the bus cycle needs when it is accepted
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         curFf <= '0;
         addrFf <= 16'h0000;
         wdataFf <= 8'h00;
      end else if (accept && busOp) begin
         curFf <= cmd;
         wdataFf <= rdReg(cmd.sel);
         case (cmd.op)
            OP_FETCH: addrFf <= pcFf;
            // port number on the low address lines
            OP_IRD, OP_IWR: addrFf <= {7'h00, cmd.imm[IO_W-1:0]};
            OP_PUSH: addrFf <= spFf - 16'h0001;
            OP_POP: addrFf <= spFf;
            // Direct address carried by the command
            default: addrFf <= cmd.imm;
         endcase
      end
   end

   // Program counter and stack pointer
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pcFf <= PC_RST;
         spFf <= SP_RST;
      end else if (accept) begin
         if (cmd.op == OP_FETCH)
            pcFf <= pcFf + 16'h0001;
         if (cmd.op == OP_PUSH)
            spFf <= spFf - 16'h0001;
         else if (cmd.op == OP_POP)
            spFf <= spFf + 16'h0001;
         else if (cmd.op == OP_LDP && cmd.sel[1:0] == SEL_SP[1:0])
            spFf <= cmd.imm;
      end
   end

   // register file, single or pair writes
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NUM_GP; i++)
            gpFf[i] <= REG_RST;
         accFf <= REG_RST;
         flgFf <= FLG_RST;
      end else if (accept && cmd.op == OP_LDP) begin
         if (cmd.sel[1:0] != SEL_SP[1:0]) begin
            gpFf[{cmd.sel[1:0], 1'b0}] <= cmd.imm[15:8];
            gpFf[{cmd.sel[1:0], 1'b1}] <= cmd.imm[7:0];
         end
      end else if (accept && cmd.op == OP_LDR) begin
         if (cmd.sel == SEL_ACC)
            accFf <= cmd.imm[7:0];
         else if (cmd.sel == SEL_FLG)
            flgFf <= cmd.imm[FLAG_W-1:0];
         else
            gpFf[cmd.sel] <= cmd.imm[7:0];
      end else if (accept && cmd.op == OP_ADD) begin
         accFf <= sum[7:0];
         // four testable flags and decimal carry
         flgFf[FLG_CY] <= sum[8];
         flgFf[FLG_Z] <= (sum[7:0] == 8'h00);
         flgFf[FLG_S] <= sum[7];
         flgFf[FLG_P] <= ~^sum[7:0];
         flgFf[FLG_AC] <= accFf[4] ^ opnd[4] ^ sum[4];
      end else if (phaseFf && stateFf == ST_T3 && !curFf.op[0]) begin
         // Read capture at the second phase of T3
         case (curFf.op)
            OP_MRD, OP_IRD: accFf <= dataIn;
            OP_POP: begin
               if (curFf.sel == SEL_ACC)
                  accFf <= dataIn;
               else if (curFf.sel == SEL_FLG)
                  flgFf <= dataIn[FLAG_W-1:0];
               else
                  gpFf[curFf.sel] <= dataIn;
            end
            default: ;
         endcase
      end
   end

   // Read result back to the engine, one-cycle pulse
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rdData <= 8'h00;
         rdValid <= 1'b0;
      end else begin
         rdValid <= phaseFf && stateFf == ST_T3 && !curFf.op[0];
         if (phaseFf && stateFf == ST_T3)
            rdData <= dataIn;
      end
   end

   // phase two running, phase one halted
   assign sampleNow = haltSt ? !phaseFf
      : phaseFf && ((accept && !busOp && cmd.last)
                   || (stateFf == ST_T4 && curFf.last));
   assign takeNow = sampleNow && irqS && irq_enabled_out;

   // Interrupt enable: a set request wins over any clear
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         irq_enabled_out <= 1'b0;
         irqTake <= 1'b0;
      end else begin
         irqTake <= takeNow;
         if (irqEnSet)
            irq_enabled_out <= 1'b1;
         else if (irqEnClr || takeNow)
            irq_enabled_out <= 1'b0;
      end
   end

   // pin drivers registered from the state
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         busOut <= '0;
         syncOut <= 1'b0;
         ioSelect <= 1'b0;
         data_in_strobe <= 1'b0;
         writeStrobe_n <= 1'b1;
         waitOut <= 1'b0;
         bus_hold_ack <= 1'b0;
      end else begin
         // float buses outside a bus cycle
         busOut.addrOe <= stateFf inside {ST_T1, ST_T2, ST_TW, ST_T3};
         busOut.addr <= addrFf;
         busOut.data <= wdataFf;
         busOut.dataOe <= curFf.op[0]
            && stateFf inside {ST_T2, ST_TW, ST_T3};
         syncOut <= (stateFf == ST_T1);
         ioSelect <= curFf.op inside {OP_IRD, OP_IWR};
         data_in_strobe <= !curFf.op[0]
            && stateFf inside {ST_T2, ST_TW, ST_T3};
         writeStrobe_n <= !(curFf.op[0] && stateFf == ST_T3);
         waitOut <= (stateFf == ST_TW);
         bus_hold_ack <= (stateFf == ST_HOLD_WAIT);
      end
   end

   property p_float;
      bus_hold_ack |-> !busOut.addrOe && !busOut.dataOe;
   endproperty
   a_float: assert property (p_float)
      else $error("bus driven during hold");
   property p_wait;
      phaseFf && stateFf == ST_T2 && !readyIn |=> stateFf == ST_TW;
   endproperty
   a_wait: assert property (p_wait)
      else $error("ready low did not add a wait");
   property p_holdIn;
      phaseFf && stateFf == ST_T4 && holdPendFf |=> ##1 bus_hold_ack;
   endproperty
   a_holdIn: assert property (p_holdIn)
      else $error("hold not acknowledged");
   property p_holdOut;
      phaseFf && stateFf == ST_HOLD_WAIT && !holdS |=> ##1 !bus_hold_ack;
   endproperty
   a_holdOut: assert property (p_holdOut)
      else $error("hold acknowledge not dropped");
   property p_take;
      irqTake |-> $past(irqS) && !irq_enabled_out;
   endproperty
   a_take: assert property (p_take)
      else $error("interrupt taken without request");
   property p_phase;
      irqTake |-> $past(phaseFf) != $past(haltSt);
   endproperty
   a_phase: assert property (p_phase)
      else $error("interrupt sampled in wrong phase");
   property p_pc;
      accept && cmd.op == OP_FETCH |=> pcFf == $past(pcFf) + 16'h0001;
   endproperty
   a_pc: assert property (p_pc)
      else $error("program counter not advanced");
   property p_push;
      accept && cmd.op == OP_PUSH |=> spFf == $past(spFf) - 16'h0001;
   endproperty
   a_push: assert property (p_push)
      else $error("stack pointer not decremented");
   property p_zero;
      accept && cmd.op == OP_ADD |=> flgFf[FLG_Z] == (accFf == 8'h00);
   endproperty
   a_zero: assert property (p_zero)
      else $error("zero flag wrong after add");
   property p_io;
      syncOut && ioSelect |-> busOut.addr[15:9] == 7'h00;
   endproperty
   a_io: assert property (p_io)
      else $error("port address above 511");
endmodule // cpu_bus_control_core

// ==== dv/bus_partner.sv ====
`timescale 1ns/10ps
module bus_partner (
   // Clock
   input wire logic clk_sys,
   // Pins from the processor
   input wire cpu_bus_pkg::bus_out_t busOut,
   input wire logic syncOut,
   input wire logic ioSelect,
   input wire logic data_in_strobe,
   input wire logic writeStrobe_n,
   input wire logic waitOut,
   // Bench setting: ready held low for waitCfg plus two clocks if not zero
   input wire logic [1:0] waitCfg,
   // Pins toward the processor
   output logic [7:0] dataIn,
   output logic readyIn
);
   import cpu_bus_pkg::*;
   logic [7:0] mem [0:65535]; // Whole memory space
   logic [15:0] wrAddr; // Last write address
   logic [7:0] wrData; // Last write data
   logic wrIo; // Last write went to an I/O port
   logic [7:0] lastOut; // Last byte driven
   logic [2:0] cnt; // Clocks since address strobe
   int nWait = 0; // Clocks with the wait pin high, two per wait state
   // drive only under strobe
   // Released bus shows the inverse, so a stale capture cannot pass
   always_comb begin
      dataIn = data_in_strobe ? mem[busOut.addr] : ~lastOut;
   end
   // Remember what was driven
   always_ff @(posedge clk_sys) begin
      if (data_in_strobe) begin
         lastOut <= dataIn;
      end
   end
   // ready is synchronous, low for waitCfg plus two clocks when waitCfg is not zero
   always_ff @(posedge clk_sys) begin
      cnt <= syncOut ? 3'h0 : (cnt == 3'h7 ? cnt : cnt + 3'h1);
      readyIn <= syncOut ? (waitCfg == 2'h0) : (cnt >= {1'b0, waitCfg});
      if (waitOut) begin
         nWait <= nWait + 1;
      end
   end
   // Capture writes; I/O writes leave memory alone
   always_ff @(posedge clk_sys) begin
      if (!writeStrobe_n) begin
         wrAddr <= busOut.addr;
         wrData <= busOut.data;
         wrIo <= ioSelect;
         if (!ioSelect) begin
            mem[busOut.addr] <= busOut.data;
         end
      end
   end
endmodule // bus_partner

// ==== dv/tb_cpu_bus_control_core.sv ====
`timescale 1ns/10ps
module tb_cpu_bus_control_core;
   import cpu_bus_pkg::*;
   // Stimulus, all given at time zero
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic cmdValid = 1'b0;
   cmd_t cmd = '0;
   logic irqEnSet = 1'b0;
   logic irqEnClr = 1'b0;
   logic holdReq = 1'b0;
   logic irqReq = 1'b0;
   logic [1:0] waitCfg = 2'h0;
   // Design outputs
   logic cmdReady, rdValid, irqTake, syncOut, ioSelect, data_in_strobe;
   logic writeStrobe_n, waitOut, bus_hold_ack, irq_enabled_out, readyIn;
   logic [7:0] rdData, dataIn;
   bus_out_t busOut;
   int n_mismatch = 0;
   int n_checks = 0;
   logic [15:0] a;
   logic [7:0] d;
   logic [7:0] y;
   logic [15:0] e;
   logic [2:0] r;
   logic seen;
   always #12.5 clk_sys = ~clk_sys;
   cpu_bus_control_core uut (.clk_sys(clk_sys), .rst(rst),
      .cmdValid(cmdValid), .cmd(cmd), .cmdReady(cmdReady),
      .rdData(rdData), .rdValid(rdValid), .irqEnSet(irqEnSet),
      .irqEnClr(irqEnClr), .irqTake(irqTake), .busOut(busOut),
      .dataIn(dataIn), .readyIn(readyIn), .holdReq(holdReq),
      .irqReq(irqReq), .syncOut(syncOut), .ioSelect(ioSelect),
      .data_in_strobe(data_in_strobe), .writeStrobe_n(writeStrobe_n),
      .waitOut(waitOut), .bus_hold_ack(bus_hold_ack),
      .irq_enabled_out(irq_enabled_out));
   bus_partner mem0 (.clk_sys(clk_sys), .busOut(busOut),
      .syncOut(syncOut), .ioSelect(ioSelect),
      .data_in_strobe(data_in_strobe), .writeStrobe_n(writeStrobe_n),
      .waitOut(waitOut), .waitCfg(waitCfg), .dataIn(dataIn),
      .readyIn(readyIn));
   // Verdict, reached from the main sequence or the watchdog
   task conclude();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Compare and count
   task check(string what, logic [15:0] exp, logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Expected add: {S, Z, AC, P, CY} above the result byte
   function automatic logic [15:0] expAdd(logic [7:0] x, logic [7:0] z);
      logic [8:0] s;
      s = {1'b0, x} + {1'b0, z};
      return {3'h0, s[7], s[7:0] == 8'h00, x[4] ^ z[4] ^ s[4], ~^s[7:0],
         s[8], s[7:0]};
   endfunction
   // Select an output to wait on
   function automatic logic sig(int w);
      case (w)
         0: return rdValid;
         1: return bus_hold_ack;
         2: return irqTake;
         default: return writeStrobe_n;
      endcase
   endfunction
   // Bounded wait, sampled mid-cycle so edge updates have landed
   task automatic waitSig(int w, logic lvl);
      int i;
      i = 0;
      while (sig(w) !== lvl && i < 300) begin
         @(negedge clk_sys);
         i++;
      end
      check("wait for output", 16'(lvl), 16'(sig(w)));
   endtask
   // Hold a command until the edge that takes it
   task automatic issue(op_t op, logic [2:0] sel, logic [15:0] imm,
                        logic last);
      int i;
      @(posedge clk_sys);
      cmdValid <= 1'b1;
      cmd <= '{op, sel, imm, last};
      i = 0;
      do begin
         @(negedge clk_sys);
         i++;
      end while (cmdReady !== 1'b1 && i < 300);
      check("command taken", 16'h0001, {15'h0, cmdReady});
      @(posedge clk_sys);
      cmdValid <= 1'b0;
   endtask
   // A write has finished once the strobe goes back high
   task wrDone();
      waitSig(3, 1'b0);
      waitSig(3, 1'b1);
   endtask
   // Read one byte and compare
   task rd(logic [15:0] addr, logic [7:0] exp);
      issue(OP_MRD, 3'h0, addr, 1'b0);
      waitSig(0, 1'b1);
      check("read data", {8'h00, exp}, {8'h00, rdData});
   endtask
   // Long enough for every test several times over
   initial begin
      #500000;
      n_mismatch++;
      conclude();
   end
   initial begin
      void'($urandom(58951));
      repeat (6) @(posedge clk_sys);
      check("pins in reset", 16'h0001, {busOut.addrOe, busOut.dataOe,
         bus_hold_ack, irq_enabled_out, writeStrobe_n});
      rst <= 1'b0;
      // Flags leave reset clear; stack them to see them
      issue(OP_LDP, SEL_SP, 16'h8000, 1'b0);
      issue(OP_PUSH, SEL_FLG, 16'h0000, 1'b0);
      wrDone();
      check("flags", {11'h0, FLG_RST}, {11'h0, mem0.wrData[4:0]});
      // Random writes and reads, with wait states, top address first
      for (int i = 0; i < 20; i++) begin
         waitCfg <= 2'($urandom_range(3));
         a = (i == 0) ? 16'hffff : 16'($urandom);
         d = 8'($urandom);
         r = 3'($urandom_range(5));
         issue(OP_LDR, r, {8'h00, d}, 1'b0);
         issue(OP_MWR, r, a, 1'b0);
         wrDone();
         check("write addr", a, mem0.wrAddr);
         check("write data", {8'h00, d}, {8'h00, mem0.wrData});
         rd(a, d);
      end
      check("wait states", 16'h0001, 16'(mem0.nWait > 0));
      waitCfg <= 2'h0;
      // Pair load: high byte to even register
      issue(OP_LDP, 3'h1, 16'ha5c3, 1'b0);
      issue(OP_MWR, 3'h2, 16'h0010, 1'b0);
      wrDone();
      check("pair high", 16'h00a5, {8'h00, mem0.wrData});
      issue(OP_MWR, 3'h3, 16'h0011, 1'b0);
      wrDone();
      check("pair low", 16'h00c3, {8'h00, mem0.wrData});
      // Push one register, pop into another
      issue(OP_LDR, 3'h4, 16'h005a, 1'b0);
      issue(OP_PUSH, 3'h4, 16'h0000, 1'b0);
      issue(OP_POP, 3'h5, 16'h0000, 1'b0);
      issue(OP_MWR, 3'h5, 16'h0020, 1'b0);
      wrDone();
      check("stack round trip", 16'h005a, {8'h00, mem0.wrData});
      // Adds with a carry-out and zero corner first, seen through the stack
      for (int k = 0; k < 3; k++) begin
         d = (k == 0) ? 8'hff : 8'($urandom);
         y = (k == 0) ? 8'h01 : 8'($urandom);
         e = expAdd(d, y);
         issue(OP_LDR, SEL_ACC, {8'h00, d}, 1'b0);
         issue(OP_LDR, 3'h2, {8'h00, y}, 1'b0);
         issue(OP_ADD, 3'h2, 16'h0000, 1'b0);
         issue(OP_PUSH, SEL_ACC, 16'h0000, 1'b0);
         wrDone();
         check("add sum", {8'h00, e[7:0]}, {8'h00, mem0.wrData});
         issue(OP_PUSH, SEL_FLG, 16'h0000, 1'b0);
         wrDone();
         check("add flags", {11'h000, e[12:8]},
            {11'h000, mem0.wrData[4:0]});
      end
      // Two fetches from the reset program counter
      issue(OP_LDP, 3'h0, 16'h3cc3, 1'b0);
      issue(OP_MWR, 3'h0, 16'h0000, 1'b0);
      issue(OP_MWR, 3'h1, 16'h0001, 1'b0);
      issue(OP_FETCH, 3'h0, 16'h0000, 1'b0);
      waitSig(0, 1'b1);
      check("fetch first", 16'h003c, {8'h00, rdData});
      issue(OP_FETCH, 3'h0, 16'h0000, 1'b0);
      waitSig(0, 1'b1);
      check("fetch second", 16'h00c3, {8'h00, rdData});
      // Highest I/O port
      issue(OP_IWR, 3'h5, 16'h01ff, 1'b0);
      wrDone();
      check("io port", 16'h11ff, {3'h0, mem0.wrIo, 3'h0,
         mem0.wrAddr[8:0]});
      issue(OP_IRD, 3'h0, 16'h0010, 1'b0);
      waitSig(0, 1'b1);
      check("io read", 16'h10a5, {3'h0, ioSelect, 4'h0, rdData});
      // hold raised during a read, held steady until acknowledged
      issue(OP_MRD, 3'h0, 16'h0010, 1'b0);
      holdReq <= 1'b1;
      waitSig(0, 1'b1);
      check("read before hold", 16'h00a5, {8'h00, rdData});
      waitSig(1, 1'b1);
      check("floated in hold", 16'h0000, {busOut.addrOe,
         busOut.dataOe, cmdReady});
      @(posedge clk_sys) holdReq <= 1'b0;
      waitSig(1, 1'b0);
      // Enabled interrupt taken at instruction end, then disabled
      @(posedge clk_sys) irqEnSet <= 1'b1;
      @(posedge clk_sys) irqEnSet <= 1'b0;
      irqReq <= 1'b1;
      repeat (3) @(posedge clk_sys);
      check("irq enabled", 16'h0001, {15'h0, irq_enabled_out});
      issue(OP_LDR, 3'h0, 16'h0000, 1'b1);
      waitSig(2, 1'b1);
      @(negedge clk_sys);
      check("irq disabled", 16'h0000, {15'h0, irq_enabled_out});
      // Disabled: request still high but never taken
      seen = 1'b0;
      issue(OP_LDR, 3'h0, 16'h0000, 1'b1);
      repeat (10) @(negedge clk_sys) seen |= (irqTake === 1'b1);
      check("masked irq", 16'h0000, {15'h0, seen});
      // Halted: request raised only after halt
      @(posedge clk_sys) irqReq <= 1'b0;
      irqEnSet <= 1'b1;
      @(posedge clk_sys) irqEnSet <= 1'b0;
      issue(OP_HALT, 3'h0, 16'h0000, 1'b1);
      repeat (4) @(posedge clk_sys);
      irqReq <= 1'b1;
      waitSig(2, 1'b1);
      // Enabled again: taken at the end of a bus instruction
      @(posedge clk_sys) irqEnSet <= 1'b1;
      @(posedge clk_sys) irqEnSet <= 1'b0;
      issue(OP_MRD, 3'h0, 16'h0010, 1'b1);
      waitSig(2, 1'b1);
      @(posedge clk_sys) irqReq <= 1'b0;
      conclude();
   end
endmodule // tb_cpu_bus_control_core
